/* rtl/pos_latch_regs.vh */
// Constants for the position counter latch and synchronization block.
// Assumes byte-addressed feedback image; included by the design file and the bench.
`ifndef POS_LATCH_REGS_VH
`define POS_LATCH_REGS_VH

// Feedback image byte offsets
`define FB_OFS_COUNT      8'h00
`define FB_OFS_ERR_LOAD   8'h04
`define FB_OFS_DIR_GATE   8'h05
`define FB_OFS_LIM_SYNC   8'h06
`define FB_OFS_RUN_COUNT  8'h08

// Error and load status byte bit positions
`define B4_SUPPLY_SHORT   7
`define B4_PARAM_ERR      5
`define B4_CLEAR_ACTIVE   2
`define B4_LOAD_ERR       1
`define B4_LOAD_RUNNING   0

// Direction, input and gate byte bit positions
`define B5_COUNT_DOWN     7
`define B5_COUNT_UP       6
`define B5_INPUT_LEVEL    1
`define B5_INT_GATE       0

// Limit and synchronization byte bit positions
`define B6_ZERO_CROSS     7
`define B6_LOW_LIMIT      6
`define B6_HIGH_LIMIT     5
`define B6_SYNC_DONE      0

// Digital input function codes
`define DI_FN_INPUT       3'h0
`define DI_FN_HW_GATE     3'h1
`define DI_FN_LATCH_RETRG 3'h2
`define DI_FN_LATCH       3'h3
`define DI_FN_SYNC        3'h4

// Reset states and counting limits
`define RST_COUNT         32'h00000000
`define RST_LOAD          32'h00000000
`define RST_LATCH         32'h00000000
`define CNT_HIGH_LIMIT    32'h7fffffff
`define CNT_LOW_LIMIT     32'h80000000
`define CNT_MINUS_ONE     32'hffffffff
`define CNT_ZERO          32'h00000000
`define CNT_STEP          32'h00000001
`define BYTE_ZERO         8'h00

`endif

/* rtl/position_counter_latch_sync.v */
// Position counter with latch, latch-and-retrigger and reference sync,
// and the cyclic feedback image read by the controller.
// Assumes count pulses and control bits come from logic on i_clk; the
// digital input and supply-short pins are asynchronous and synchronised.
`timescale 1ns/1ps
`include "pos_latch_regs.vh"

module position_counter_latch_sync #(
	parameter CNT_W = 32
) (
	// Clock, reset, enable
	input  wire             i_clk,
	input  wire             i_rst_n,
	input  wire             i_ce,
	// Parameter assignment
	input  wire             i_param_load,
	input  wire [2:0]       i_di_function,
	input  wire             i_gate_interrupt,
	input  wire             i_hw_gate_inverted,
	input  wire             i_sync_periodic,
	input  wire             i_ext_iface,
	// Controller control bits and values
	input  wire             i_soft_gate_ctl,
	input  wire             i_sync_enable_ctl,
	input  wire             i_status_clear_request,
	input  wire             i_load_direct,
	input  wire             i_load_prepare,
	input  wire [CNT_W-1:0] i_load_value,
	// Isochrone timing
	input  wire             i_isochrone,
	input  wire             i_sample_ti,
	// Count pulses from the encoder front end
	input  wire             i_cnt_up,
	input  wire             i_cnt_dn,
	// Pins
	input  wire             i_aux_digital_input,
	input  wire             i_supply_short,
	// Feedback image
	output reg  [CNT_W-1:0] o_fb_count,
	output reg  [7:0]       o_fb_err_load,
	output reg  [7:0]       o_fb_dir_gate,
	output reg  [7:0]       o_fb_lim_sync,
	output reg  [CNT_W-1:0] o_fb_run_count
);

	// Input function decode of latch and retrigger modes, used to pick the shown count
	function is_latch_mode;
		input [2:0] fn;
		begin
			is_latch_mode = (fn == `DI_FN_LATCH) ||
				(fn == `DI_FN_LATCH_RETRG);
		end
	endfunction

	// Edge decode of a level against its value one cycle earlier
	function edge_rise;
		input cur;
		input prev;
		begin
			edge_rise = cur & ~prev;
		end
	endfunction

	function edge_fall;
		input cur;
		input prev;
		begin
			edge_fall = ~cur & prev;
		end
	endfunction

	// Synchroniser stages, one slot per pin, and edge history of the digital input only
	localparam PIN_N     = 2;
	localparam PIN_DI    = 0;
	localparam PIN_SHORT = 1;
	genvar          gp;
	reg [PIN_N-1:0] pin_meta_q;
	reg [PIN_N-1:0] pin_sync_q;
	reg             di_prev_q;
	// Gates and counter state
	reg             soft_ctl_prev_q;
	reg             soft_gate_q;
	reg             int_gate_prev_q;
	reg             started_q;
	reg [CNT_W-1:0] count_q;
	reg [CNT_W-1:0] count_d;
	reg [CNT_W-1:0] load_val_q;
	reg [CNT_W-1:0] latch_q;
	// Status
	reg             sync_used_q;
	reg             dir_up_q;
	reg             dir_dn_q;
	reg             dir_up_d;
	reg             dir_dn_d;
	reg             clear_active_q;
	reg             clear_prev_q;
	reg             load_run_q;
	reg             wrap_hi_d;
	reg             wrap_lo_d;
	reg             zero_d;
	// Sticky flag slots, all cleared by one status clear request
	localparam ST_SYNC  = 0;
	localparam ST_ZERO  = 1;
	localparam ST_LOW   = 2;
	localparam ST_HIGH  = 3;
	localparam ST_LDERR = 4;
	localparam ST_N     = 5;
	genvar          gs;
	reg [ST_N-1:0]  sticky_q;
	reg [ST_N-1:0]  sticky_set;
	// Next image, assembled apart so each group loads in one edge
	reg [CNT_W-1:0] shown_count_d;
	reg [CNT_W-1:0] run_count_d;
	reg [7:0]       err_load_d;
	reg [7:0]       dir_gate_d;
	reg [7:0]       lim_sync_d;

	// Combinational decode of the current cycle
	wire [PIN_N-1:0] pin_raw = {i_supply_short, i_aux_digital_input};
	wire di_level   = pin_sync_q[PIN_DI];
	wire short_lvl  = pin_sync_q[PIN_SHORT];
	wire di_rise    = edge_rise(di_level, di_prev_q);
	wire fn_latch   = (i_di_function == `DI_FN_LATCH);
	wire fn_retrg   = (i_di_function == `DI_FN_LATCH_RETRG);
	wire fn_sync    = (i_di_function == `DI_FN_SYNC);
	wire fn_hw_gate = (i_di_function == `DI_FN_HW_GATE);
	wire hw_gate    = fn_hw_gate ?
		(di_level ^ i_hw_gate_inverted) : 1'b1;
	wire int_gate   = soft_gate_q & hw_gate;
	wire gate_open  = edge_rise(int_gate, int_gate_prev_q);
	wire gate_close = edge_fall(int_gate, int_gate_prev_q);
	wire soft_rise  = edge_rise(i_soft_gate_ctl, soft_ctl_prev_q);
	wire param_err  = (i_di_function > `DI_FN_SYNC) ||
		(i_hw_gate_inverted & ~fn_hw_gate);
	// Retrigger armed once the soft gate has opened at least once
	wire retrg_ev   = fn_retrg & di_rise & started_q;
	wire latch_ev   = (fn_latch & di_rise) | retrg_ev;
	// Sync needs running soft gate and enable; once-only skips reuse
	wire sync_ev    = fn_sync & di_rise & soft_gate_q &
		i_sync_enable_ctl &
		(i_sync_periodic | ~sync_used_q);
	wire step_up    = int_gate & i_cnt_up & ~i_cnt_dn;
	wire step_dn    = int_gate & i_cnt_dn & ~i_cnt_up;
	// Cancel-type reload on gate open; retrigger mode only pauses
	wire open_load  = gate_open & ~fn_retrg &
		(~started_q | ~i_gate_interrupt);
	wire clear_rise = edge_rise(i_status_clear_request, clear_prev_q);
	wire fb_take    = ~i_isochrone | i_sample_ti;

	// Next count: loads beat pulses; wrap follows two's complement
	always @* begin
		count_d   = count_q;
		wrap_hi_d = 1'b0;
		wrap_lo_d = 1'b0;
		zero_d    = 1'b0;
		if (i_load_direct) begin
			count_d = i_load_value;
		end else if (retrg_ev || sync_ev || open_load) begin
			count_d = load_val_q;
		end else if (step_up) begin
			count_d   = count_q + `CNT_STEP;
			wrap_hi_d = (count_q == `CNT_HIGH_LIMIT);
			zero_d    = (count_q == `CNT_MINUS_ONE);
		end else if (step_dn) begin
			count_d   = count_q - `CNT_STEP;
			wrap_lo_d = (count_q == `CNT_LOW_LIMIT);
			zero_d    = (count_q == `CNT_ZERO);
		end
	end

	// Pin synchronisers; first stage feeds only the second
	generate
		for (gp = 0; gp < PIN_N; gp = gp + 1) begin : g_pin_sync
			always @(posedge i_clk) begin
				if (!i_rst_n) begin
					pin_meta_q[gp] <= 1'b0;
					pin_sync_q[gp] <= 1'b0;
				end else if (i_ce) begin
					pin_meta_q[gp] <= pin_raw[gp];
					pin_sync_q[gp] <= pin_meta_q[gp];
				end
			end
		end
	endgenerate

	// Edge history; resets low, the idle level, so no false edge
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			di_prev_q <= 1'b0;
		end else if (i_ce) begin
			di_prev_q <= di_level;
		end
	end

	// Soft gate opens only on a control rising edge, closes on low
	always @(posedge i_clk) begin
		if (!i_rst_n || i_param_load) begin
			soft_ctl_prev_q <= 1'b0;
			soft_gate_q     <= 1'b0;
			int_gate_prev_q <= 1'b0;
			started_q       <= 1'b0;
		end else if (i_ce) begin
			soft_ctl_prev_q <= i_soft_gate_ctl;
			int_gate_prev_q <= int_gate;
			if (!i_soft_gate_ctl) begin
				soft_gate_q <= 1'b0;
			end else if (soft_rise) begin
				soft_gate_q <= 1'b1;
			end
			if (gate_open) begin
				started_q <= 1'b1;
			end
		end
	end

	// Counter, prepared load value and captured count
	always @(posedge i_clk) begin
		if (!i_rst_n || i_param_load) begin
			count_q    <= `RST_COUNT;
			load_val_q <= `RST_LOAD;
			latch_q    <= `RST_LATCH;
		end else if (i_ce) begin
			count_q <= count_d;
			if (i_load_prepare) begin
				load_val_q <= i_load_value;
			end
			// Capture the pre-reload count; direct load never touches it
			if (latch_ev) begin
				latch_q <= count_q;
			end
		end
	end

	// Once-only sync bookkeeping; re-arms when enable drops
	always @(posedge i_clk) begin
		if (!i_rst_n || i_param_load) begin
			sync_used_q <= 1'b0;
		end else if (i_ce) begin
			if (!i_sync_enable_ctl) begin
				sync_used_q <= 1'b0;
			end else if (sync_ev) begin
				sync_used_q <= 1'b1;
			end
		end
	end

	// Status clear handshake: active follows the request bit
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			clear_prev_q   <= 1'b0;
			clear_active_q <= 1'b0;
		end else if (i_ce) begin
			clear_prev_q   <= i_status_clear_request;
			clear_active_q <= i_status_clear_request;
		end
	end

	// Set requests of the sticky flags
	always @* begin
		sticky_set           = {ST_N{1'b0}};
		sticky_set[ST_SYNC]  = sync_ev;
		sticky_set[ST_ZERO]  = zero_d;
		sticky_set[ST_LOW]   = wrap_lo_d;
		sticky_set[ST_HIGH]  = wrap_hi_d;
		// Both load strobes at once is ambiguous, flag it
		sticky_set[ST_LDERR] = i_load_direct & i_load_prepare;
	end

	// Sticky flags; a new event in the clear cycle wins
	generate
		for (gs = 0; gs < ST_N; gs = gs + 1) begin : g_sticky
			always @(posedge i_clk) begin
				if (!i_rst_n || i_param_load) begin
					sticky_q[gs] <= 1'b0;
				end else if (i_ce) begin
					sticky_q[gs] <= sticky_set[gs] |
						(sticky_q[gs] & ~clear_rise);
				end
			end
		end
	endgenerate

	// Direction shows the last step taken; cleared on gate close
	always @* begin
		dir_up_d = dir_up_q;
		dir_dn_d = dir_dn_q;
		if (step_up) begin
			dir_up_d = 1'b1;
			dir_dn_d = 1'b0;
		end else if (step_dn) begin
			dir_up_d = 1'b0;
			dir_dn_d = 1'b1;
		end else if (gate_close) begin
			dir_up_d = 1'b0;
			dir_dn_d = 1'b0;
		end
	end

	// Direction flops; load-running is one cycle
	always @(posedge i_clk) begin
		if (!i_rst_n || i_param_load) begin
			dir_up_q   <= 1'b0;
			dir_dn_q   <= 1'b0;
			load_run_q <= 1'b0;
		end else if (i_ce) begin
			load_run_q <= i_load_direct | i_load_prepare;
			dir_up_q   <= dir_up_d;
			dir_dn_q   <= dir_dn_d;
		end
	end

	// Feedback image: every group reloads in one edge, so a reader
	// never sees a mix of old and new bytes. In isochrone mode the
	// image is frozen between sample instants, so the captured count
	// and sync flag are those valid at the last sample.
	always @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_fb_count     <= `RST_COUNT;
			o_fb_err_load  <= `BYTE_ZERO;
			o_fb_dir_gate  <= `BYTE_ZERO;
			o_fb_lim_sync  <= `BYTE_ZERO;
			o_fb_run_count <= `RST_COUNT;
		end else if (i_ce && fb_take) begin
			o_fb_count     <= shown_count_d;
			o_fb_err_load  <= err_load_d;
			o_fb_dir_gate  <= dir_gate_d;
			o_fb_lim_sync  <= lim_sync_d;
			o_fb_run_count <= run_count_d;
		end
	end

	// Next image bytes; reserved bits stay zero
	always @* begin
		err_load_d = `BYTE_ZERO;
		dir_gate_d = `BYTE_ZERO;
		lim_sync_d = `BYTE_ZERO;
		err_load_d[`B4_SUPPLY_SHORT] = short_lvl;
		err_load_d[`B4_PARAM_ERR]    = param_err;
		err_load_d[`B4_CLEAR_ACTIVE] = clear_active_q;
		err_load_d[`B4_LOAD_ERR]     = sticky_q[ST_LDERR];
		err_load_d[`B4_LOAD_RUNNING] = load_run_q;
		dir_gate_d[`B5_COUNT_DOWN]   = dir_dn_q;
		dir_gate_d[`B5_COUNT_UP]     = dir_up_q;
		dir_gate_d[`B5_INPUT_LEVEL]  = di_level;
		dir_gate_d[`B5_INT_GATE]     = int_gate;
		lim_sync_d[`B6_ZERO_CROSS]   = sticky_q[ST_ZERO];
		lim_sync_d[`B6_LOW_LIMIT]    = sticky_q[ST_LOW];
		lim_sync_d[`B6_HIGH_LIMIT]   = sticky_q[ST_HIGH];
		lim_sync_d[`B6_SYNC_DONE]    = sticky_q[ST_SYNC];
		shown_count_d = is_latch_mode(i_di_function) ?
			latch_q : count_q;
		// Running count only on the extended image, else zero
		run_count_d = i_ext_iface ?
			count_q : `RST_COUNT;
	end

endmodule

/* tb/pos_latch_chk.sv */
// Checker on the feedback image ports of the position counter.
// Assumes it is bound to the design top; one clock domain.
`timescale 1ns/1ps
module pos_latch_chk #(
	parameter CNT_W = 32
) (
	input logic             i_clk,
	input logic             i_rst_n,
	input logic             i_ce,
	input logic [2:0]       i_di_function,
	input logic             i_ext_iface,
	input logic             i_status_clear_request,
	input logic             i_isochrone,
	input logic             i_sample_ti,
	input logic             i_aux_digital_input,
	input logic [CNT_W-1:0] o_fb_count,
	input logic [7:0]       o_fb_err_load,
	input logic [7:0]       o_fb_dir_gate,
	input logic [7:0]       o_fb_lim_sync,
	input logic [CNT_W-1:0] o_fb_run_count
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	// Four samples cover the two-edge lag of the image
	sequence s_clr_on;
		(i_ce && !i_isochrone && i_status_clear_request) [*4];
	endsequence
	sequence s_clr_off;
		(i_ce && !i_isochrone && !i_status_clear_request) [*4];
	endsequence
	property p_reserved;
		(o_fb_err_load & 8'h58) == 8'h00 && (o_fb_dir_gate & 8'h3c) == 8'h00
			&& (o_fb_lim_sync & 8'h1e) == 8'h00;
	endproperty
	property p_run_off;
		i_ce && !i_isochrone && !i_ext_iface |=> o_fb_run_count == '0;
	endproperty
	property p_param;
		(i_ce && !i_isochrone && i_di_function > 3'h4) [*3]
			|=> o_fb_err_load[5];
	endproperty
	// Level passes two synchroniser stages, then the image
	property p_level;
		(i_ce && !i_isochrone && $stable(i_aux_digital_input)) [*5]
			|-> o_fb_dir_gate[1] == i_aux_digital_input;
	endproperty
	property p_clr_on;
		s_clr_on |-> o_fb_err_load[2];
	endproperty
	property p_clr_off;
		s_clr_off |-> !o_fb_err_load[2];
	endproperty
	property p_same;
		(i_ce && !i_isochrone && i_ext_iface && i_di_function == 3'h0) [*3]
			|-> o_fb_count == o_fb_run_count;
	endproperty
	property p_iso;
		i_isochrone && !i_sample_ti
			|=> $stable(o_fb_count) && $stable(o_fb_lim_sync);
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved image bit set");
	a_run_off: assert property (p_run_off)
		else $error("running count shown without extended image");
	a_param: assert property (p_param)
		else $error("parameter error not flagged");
	a_level: assert property (p_level)
		else $error("input level bit differs from pin");
	a_clr_on: assert property (p_clr_on)
		else $error("status clear active missing");
	a_clr_off: assert property (p_clr_off)
		else $error("status clear active stuck");
	a_same: assert property (p_same)
		else $error("count groups disagree");
	a_iso: assert property (p_iso)
		else $error("image moved between sample instants");
endmodule

bind position_counter_latch_sync pos_latch_chk #(.CNT_W(CNT_W)) i_chk (
	.i_clk, .i_rst_n, .i_ce, .i_di_function, .i_ext_iface,
	.i_status_clear_request, .i_isochrone, .i_sample_ti,
	.i_aux_digital_input, .o_fb_count, .o_fb_err_load, .o_fb_dir_gate,
	.o_fb_lim_sync, .o_fb_run_count
);

/* tb/pos_encoder_model.sv */
// Encoder front end model: one count pulse per cycle on request.
// Assumes the bench asks for steps by level, on the design clock.
`timescale 1ns/1ps
module pos_encoder_model (
	// Clock and request
	input  logic i_clk,
	input  logic i_run,
	input  logic i_dir,
	// Count pulses
	output logic o_cnt_up = 1'h0,
	output logic o_cnt_dn = 1'h0
);
	// Never both lines at once, so no step is cancelled
	always @(posedge i_clk) begin
		o_cnt_up <= i_run && !i_dir;
		o_cnt_dn <= i_run && i_dir;
	end
endmodule

/* tb/tb.sv */
// Bench for the position counter latch and sync block.
// Assumes the design, its header and the encoder model compile first.
`timescale 1ns/1ps
`include "pos_latch_regs.vh"
module tb;
	logic        i_clk = 1'h0, i_rst_n = 1'h0, i_param_load = 1'h0;
	logic        i_sync_periodic = 1'h0, i_ext_iface = 1'h1;
	logic        i_soft_gate_ctl = 1'h0, i_sync_enable_ctl = 1'h0;
	logic        i_status_clear_request = 1'h0, i_load_direct = 1'h0;
	logic        i_load_prepare = 1'h0, i_isochrone = 1'h0;
	logic        i_sample_ti = 1'h0, i_aux_digital_input = 1'h0;
	logic        run = 1'h0, dir = 1'h0, cnt_up, cnt_dn;
	logic        short_in = 1'h0, gint = 1'h1;
	logic [2:0]  i_di_function = 3'h0;
	logic [7:0]  fb_el, fb_dg, fb_ls;
	logic [31:0] i_load_value = 32'h0, fb_cnt, fb_run, m_cnt, m_lat;
	int          failures = 0, checks = 0, seed = 44;

	// Free-running 100 MHz clock
	always #5 i_clk = ~i_clk;

	// Clock enable and gate inversion stay at their defaults
	position_counter_latch_sync i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_ce(1'h1), .i_param_load(i_param_load),
		.i_di_function(i_di_function), .i_gate_interrupt(gint),
		.i_hw_gate_inverted(1'h0), .i_sync_periodic(i_sync_periodic),
		.i_ext_iface(i_ext_iface), .i_soft_gate_ctl(i_soft_gate_ctl),
		.i_sync_enable_ctl(i_sync_enable_ctl),
		.i_status_clear_request(i_status_clear_request),
		.i_load_direct(i_load_direct), .i_load_prepare(i_load_prepare),
		.i_load_value(i_load_value), .i_isochrone(i_isochrone),
		.i_sample_ti(i_sample_ti), .i_cnt_up(cnt_up), .i_cnt_dn(cnt_dn),
		.i_aux_digital_input(i_aux_digital_input), .i_supply_short(short_in),
		.o_fb_count(fb_cnt), .o_fb_err_load(fb_el), .o_fb_dir_gate(fb_dg),
		.o_fb_lim_sync(fb_ls), .o_fb_run_count(fb_run));
	pos_encoder_model i_enc (.i_clk(i_clk), .i_run(run), .i_dir(dir),
		.o_cnt_up(cnt_up), .o_cnt_dn(cnt_dn));

	task automatic results;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Waits end past the edge so outputs have settled
	task automatic wt(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	// Parameter assignment also closes the gate, so reopen is an edge
	task automatic mode(input logic [2:0] f, input logic p);
		@(posedge i_clk);
		i_di_function <= f;
		i_sync_periodic <= p;
		i_soft_gate_ctl <= 1'h0;
		i_param_load <= 1'h1;
		@(posedge i_clk) i_param_load <= 1'h0;
		wt(3);
		m_cnt = 0;
		m_lat = 0;
	endtask
	task automatic gate(input logic v);
		@(posedge i_clk) i_soft_gate_ctl <= v;
		wt(3);
	endtask
	task automatic ld(input logic d, input logic [31:0] v);
		@(posedge i_clk);
		i_load_value <= v;
		i_load_direct <= d;
		i_load_prepare <= !d;
		@(posedge i_clk);
		i_load_direct <= 1'h0;
		i_load_prepare <= 1'h0;
		wt(3);
	endtask
	task automatic steps(input int n, input logic d);
		@(posedge i_clk);
		run <= 1'h1;
		dir <= d;
		repeat (n) @(posedge i_clk);
		run <= 1'h0;
		wt(4);
	endtask
	// Pin held long enough for the synchroniser to see each level
	task automatic edge_in;
		@(posedge i_clk) i_aux_digital_input <= 1'h1;
		wt(6);
		cmp("level", {31'h0, !i_isochrone}, fb_dg[1]);
		@(posedge i_clk) i_aux_digital_input <= 1'h0;
		wt(4);
	endtask

	// Bounded run time
	initial begin
		repeat (20000) @(posedge i_clk);
		failures++;
		results;
	end

	initial begin
		wt(8);
		@(posedge i_clk) i_rst_n <= 1'h1;
		wt(2);
		cmp("count", 32'h0, fb_cnt);
		mode(`DI_FN_LATCH, 1'h0);
		m_cnt = $random(seed) & 32'hffff;
		ld(1'h0, m_cnt);
		gate(1'h1);
		steps(10, 1'h0);
		m_cnt += 10;
		cmp("count", m_lat, fb_cnt);
		cmp("run", m_cnt, fb_run);
		cmp("gate", 32'h1, fb_dg[0]);
		cmp("up", 32'h1, fb_dg[6]);
		edge_in;
		cmp("count", m_cnt, fb_cnt);
		ld(1'h1, 32'h7);
		cmp("count", m_cnt, fb_cnt);
		gate(1'h0);
		steps(3, 1'h0);
		edge_in;
		cmp("count", 32'h7, fb_cnt);
		mode(`DI_FN_LATCH_RETRG, 1'h0);
		ld(1'h0, 32'h32);
		edge_in;
		cmp("run", 32'h0, fb_run);
		gate(1'h1);
		steps(5, 1'h0);
		edge_in;
		cmp("count", 32'h5, fb_cnt);
		cmp("run", 32'h32, fb_run);
		gate(1'h0);
		steps(4, 1'h0);
		cmp("run", 32'h32, fb_run);
		mode(`DI_FN_SYNC, 1'h0);
		gate(1'h1);
		ld(1'h0, 32'hc8);
		steps(3, 1'h0);
		edge_in;
		cmp("run", 32'h3, fb_run);
		@(posedge i_clk) i_sync_enable_ctl <= 1'h1;
		edge_in;
		steps(2, 1'h0);
		edge_in;
		cmp("run", 32'hca, fb_run);
		cmp("sync", 32'h1, fb_ls[0]);
		@(posedge i_clk) i_status_clear_request <= 1'h1;
		wt(4);
		cmp("sync", 32'h0, fb_ls[0]);
		cmp("active", 32'h1, fb_el[2]);
		@(posedge i_clk) i_status_clear_request <= 1'h0;
		mode(`DI_FN_SYNC, 1'h1);
		gate(1'h1);
		ld(1'h0, 32'h9);
		edge_in;
		steps(1, 1'h0);
		edge_in;
		cmp("run", 32'h9, fb_run);
		mode(3'h5, 1'h0);
		cmp("param", 32'h1, fb_el[5]);
		@(posedge i_clk) short_in <= 1'h1;
		wt(5);
		cmp("short", 32'h1, fb_el[7]);
		@(posedge i_clk) short_in <= 1'h0;
		wt(5);
		cmp("short", 32'h0, fb_el[7]);
		// Hardware gate: internal gate is soft gate AND input level
		mode(`DI_FN_HW_GATE, 1'h0);
		gate(1'h1);
		cmp("gate", 32'h0, fb_dg[0]);
		@(posedge i_clk) i_aux_digital_input <= 1'h1;
		wt(5);
		cmp("gate", 32'h1, fb_dg[0]);
		@(posedge i_clk) i_aux_digital_input <= 1'h0;
		wt(5);
		cmp("gate", 32'h0, fb_dg[0]);
		// Cancelling gate: reopen restarts from the load value
		@(posedge i_clk) gint <= 1'h0;
		mode(`DI_FN_LATCH, 1'h0);
		ld(1'h0, 32'h40);
		gate(1'h1);
		steps(2, 1'h0);
		cmp("run", 32'h42, fb_run);
		gate(1'h0);
		gate(1'h1);
		cmp("run", 32'h40, fb_run);
		@(posedge i_clk) gint <= 1'h1;
		mode(`DI_FN_INPUT, 1'h0);
		gate(1'h1);
		ld(1'h1, `CNT_HIGH_LIMIT);
		steps(1, 1'h0);
		cmp("run", `CNT_LOW_LIMIT, fb_run);
		cmp("high", 32'h1, fb_ls[5]);
		steps(1, 1'h1);
		cmp("run", `CNT_HIGH_LIMIT, fb_run);
		cmp("low", 32'h1, fb_ls[6]);
		cmp("down", 32'h1, fb_dg[7]);
		@(posedge i_clk) i_ext_iface <= 1'h0;
		wt(3);
		cmp("run", 32'h0, fb_run);
		mode(`DI_FN_LATCH, 1'h0);
		gate(1'h1);
		@(posedge i_clk) i_isochrone <= 1'h1;
		steps(5, 1'h0);
		edge_in;
		cmp("count", 32'h0, fb_cnt);
		@(posedge i_clk) i_sample_ti <= 1'h1;
		@(posedge i_clk) i_sample_ti <= 1'h0;
		wt(2);
		cmp("count", 32'h5, fb_cnt);
		results;
	end
endmodule
